// >>> shared/tbpaf_pkg.sv
package tbpaf_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int IDX_W = 12;
    localparam logic [11:0] IDX_TP_LATCH = 12'h008;
    localparam logic [11:0] IDX_UP_LATCH = 12'h009;
    localparam logic [11:0] IDX_BP_LATCH = 12'h00B;
    localparam logic [11:0] IDX_TP_READ = 12'h015;
    localparam logic [11:0] IDX_UP_READ = 12'h016;
    localparam logic [11:0] IDX_BP_READ = 12'h018;
    localparam logic [11:0] IDX_TP_DIR = 12'hF22;
    localparam logic [11:0] IDX_UP_DIR = 12'hF23;
    localparam logic [11:0] IDX_BP_DIR = 12'hF25;
    localparam logic [11:0] IDX_UP_PULLUP = 12'hF30;
    localparam logic [11:0] IDX_TP_FUNC = 12'hF3C;
    localparam logic [11:0] IDX_UP_FUNC = 12'hF3D;
    localparam logic [11:0] IDX_UP_OTYPE = 12'hF4A;
    localparam logic [11:0] IDX_BP_OTYPE = 12'hF4C;
    localparam logic [11:0] IDX_UART_ROUTE = 12'hF57;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int PORT2_W = 2;
    localparam int PORTB_W = 4;
    localparam int PORTB_LSB = 4;
    localparam int SWAP_BIT = 1;
    localparam logic [1:0] RST_PORT2 = 2'h0;
    localparam logic [3:0] RST_PORTB = 4'h0;
    localparam logic RST_SWAP = 1'b0;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

// >>> verilog/tbpaf_pin_cell.sv
module tbpaf_pin_cell #(
    parameter int W = 2
) (
    input wire logic [W-1:0] dir,
    input wire logic [W-1:0] func_sel,
    input wire logic [W-1:0] open_drain,
    input wire logic [W-1:0] pullup_req,
    input wire logic [W-1:0] latch,
    input wire logic [W-1:0] alt_out,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe_n,
    output logic [W-1:0] pullup_on,
    output logic [W-1:0] readback
);

    // ----------------------------------------------------------------
    // Output path
    // ----------------------------------------------------------------
    logic [W-1:0] drive_val;

    // Alternate function or latch picks the level
    assign drive_val = (func_sel & alt_out) | (~func_sel & latch);

    // Open drain only ever sinks, so a high releases the pin
    assign pin_out = drive_val & ~open_drain;
    assign pin_oe_n = ~(dir & ~(open_drain & drive_val));

    // ----------------------------------------------------------------
    // Pull-up and readback
    // ----------------------------------------------------------------
    // Pull-up honoured only where nothing pushes high
    assign pullup_on = pullup_req & (~dir | open_drain);

    // Driven push-pull pins read zero, input or open drain read the pin
    assign readback = pin_in & (~dir | open_drain);

endmodule

// >>> verilog/tbpaf_top.sv
module tbpaf_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    input wire logic [1:0] tp_pin_in,
    output logic [1:0] tp_pin_out,
    output logic [1:0] tp_pin_oe_n,
    input wire logic [1:0] up_pin_in,
    output logic [1:0] up_pin_out,
    output logic [1:0] up_pin_oe_n,
    output logic [1:0] up_pullup_on,
    input wire logic [3:0] bp_pin_in,
    output logic [3:0] bp_pin_out,
    output logic [3:0] bp_pin_oe_n,
    input wire logic pulse_out_a,
    input wire logic pulse_out_b,
    input wire logic pwm_out_a,
    input wire logic pwm_out_b,
    output logic timer_capture_in_a,
    output logic timer_capture_in_b,
    input wire logic uart_b_transmit,
    output logic uart_b_receive
);

    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    logic acc_take;
    logic addr_ok;
    logic [11:0] aidx;
    logic wr_q;
    logic [11:0] widx_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Upper address bits must be zero and the word aligned
    assign addr_ok = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0);
    assign aidx = haddr[13:2];
    assign acc_take = hsel && hready && htrans[1];

    // Never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp = tbpaf_pkg::HRESP_OKAY;
    assign hrdata = rdata_q;

    // Pending write, finished in the data phase with hwdata
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            widx_q <= 12'h000;
        end else begin
            wr_q <= acc_take && hwrite && addr_ok;
            widx_q <= aidx;
        end
    end

    function automatic logic wr_hit(input logic pend, input logic [11:0] widx,
                                    input logic [11:0] idx);
        wr_hit = pend && (widx == idx);
    endfunction

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [1:0] tp_latch_q, tp_latch_d;
    logic [1:0] tp_dir_q, tp_dir_d;
    logic [1:0] tp_func_q, tp_func_d;
    logic [1:0] up_latch_q, up_latch_d;
    logic [1:0] up_dir_q, up_dir_d;
    logic [1:0] up_func_q, up_func_d;
    logic [1:0] up_otype_q, up_otype_d;
    logic [1:0] up_pullup_q, up_pullup_d;
    logic [3:0] bp_latch_q, bp_latch_d;
    logic [3:0] bp_dir_q, bp_dir_d;
    logic [3:0] bp_otype_q, bp_otype_d;
    logic swap_q, swap_d;

    // Next values; only implemented bits take write data
    always_comb begin
        tp_latch_d = tp_latch_q;
        tp_dir_d = tp_dir_q;
        tp_func_d = tp_func_q;
        up_latch_d = up_latch_q;
        up_dir_d = up_dir_q;
        up_func_d = up_func_q;
        up_otype_d = up_otype_q;
        up_pullup_d = up_pullup_q;
        bp_latch_d = bp_latch_q;
        bp_dir_d = bp_dir_q;
        bp_otype_d = bp_otype_q;
        swap_d = swap_q;
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_TP_LATCH)) begin
            tp_latch_d = hwdata[1:0];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_TP_DIR)) begin
            tp_dir_d = hwdata[1:0];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_TP_FUNC)) begin
            tp_func_d = hwdata[1:0];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_UP_LATCH)) begin
            up_latch_d = hwdata[1:0];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_UP_DIR)) begin
            up_dir_d = hwdata[1:0];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_UP_FUNC)) begin
            up_func_d = hwdata[1:0];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_UP_OTYPE)) begin
            up_otype_d = hwdata[1:0];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_UP_PULLUP)) begin
            up_pullup_d = hwdata[1:0];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_BP_LATCH)) begin
            bp_latch_d = hwdata[7:4];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_BP_DIR)) begin
            bp_dir_d = hwdata[7:4];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_BP_OTYPE)) begin
            bp_otype_d = hwdata[7:4];
        end
        if (wr_hit(wr_q, widx_q, tbpaf_pkg::IDX_UART_ROUTE)) begin
            swap_d = hwdata[tbpaf_pkg::SWAP_BIT];
        end
    end

    // Timer port state; reset leaves inputs with port function
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tp_latch_q <= tbpaf_pkg::RST_PORT2;
            tp_dir_q <= tbpaf_pkg::RST_PORT2;
            tp_func_q <= tbpaf_pkg::RST_PORT2;
        end else begin
            tp_latch_q <= tp_latch_d;
            tp_dir_q <= tp_dir_d;
            tp_func_q <= tp_func_d;
        end
    end

    // UART port state; push-pull and pull-ups off after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_latch_q <= tbpaf_pkg::RST_PORT2;
            up_dir_q <= tbpaf_pkg::RST_PORT2;
            up_func_q <= tbpaf_pkg::RST_PORT2;
            up_otype_q <= tbpaf_pkg::RST_PORT2;
            up_pullup_q <= tbpaf_pkg::RST_PORT2;
            swap_q <= tbpaf_pkg::RST_SWAP;
        end else begin
            up_latch_q <= up_latch_d;
            up_dir_q <= up_dir_d;
            up_func_q <= up_func_d;
            up_otype_q <= up_otype_d;
            up_pullup_q <= up_pullup_d;
            swap_q <= swap_d;
        end
    end

    // Upper 4-bit port state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bp_latch_q <= tbpaf_pkg::RST_PORTB;
            bp_dir_q <= tbpaf_pkg::RST_PORTB;
            bp_otype_q <= tbpaf_pkg::RST_PORTB;
        end else begin
            bp_latch_q <= bp_latch_d;
            bp_dir_q <= bp_dir_d;
            bp_otype_q <= bp_otype_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin cells
    // ----------------------------------------------------------------
    logic [1:0] tp_rb;
    logic [1:0] up_rb;
    logic [3:0] bp_rb;
    logic [1:0] tp_alt;
    logic [1:0] up_alt;

    // Timer drives only one of pulse or PWM at a time, so merge them
    assign tp_alt = {pulse_out_b | pwm_out_b, pulse_out_a | pwm_out_a};
    // Transmit only on the pin the swap bit names; the receive pin keeps its latch
    assign up_alt = swap_q ? {uart_b_transmit, up_latch_q[0]}
                           : {up_latch_q[1], uart_b_transmit};

    tbpaf_pin_cell #(.W(tbpaf_pkg::PORT2_W)) u_tp_cell (
        .dir(tp_dir_q),
        .func_sel(tp_func_q),
        .open_drain(2'h0),
        .pullup_req(2'h0),
        .latch(tp_latch_q),
        .alt_out(tp_alt),
        .pin_in(tp_pin_in),
        .pin_out(tp_pin_out),
        .pin_oe_n(tp_pin_oe_n),
        .pullup_on(),
        .readback(tp_rb)
    );

    tbpaf_pin_cell #(.W(tbpaf_pkg::PORT2_W)) u_up_cell (
        .dir(up_dir_q),
        .func_sel(up_func_q),
        .open_drain(up_otype_q),
        .pullup_req(up_pullup_q),
        .latch(up_latch_q),
        .alt_out(up_alt),
        .pin_in(up_pin_in),
        .pin_out(up_pin_out),
        .pin_oe_n(up_pin_oe_n),
        .pullup_on(up_pullup_on),
        .readback(up_rb)
    );

    // Alternate serial outputs of this port are routed elsewhere
    tbpaf_pin_cell #(.W(tbpaf_pkg::PORTB_W)) u_bp_cell (
        .dir(bp_dir_q),
        .func_sel(4'h0),
        .open_drain(bp_otype_q),
        .pullup_req(4'h0),
        .latch(bp_latch_q),
        .alt_out(4'h0),
        .pin_in(bp_pin_in),
        .pin_out(bp_pin_out),
        .pin_oe_n(bp_pin_oe_n),
        .pullup_on(),
        .readback(bp_rb)
    );

    // Capture inputs see the pin only in input mode
    assign timer_capture_in_a = tp_pin_in[0] & ~tp_dir_q[0];
    assign timer_capture_in_b = tp_pin_in[1] & ~tp_dir_q[1];

    // Receive from the upper pin unless swapped
    assign uart_b_receive = swap_q ? up_pin_in[0] : up_pin_in[1];

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Uses next values so a read right after a write sees the new data
    always_comb begin
        rdata_d = 32'h00000000;
        if (addr_ok) begin
            case (aidx)
                tbpaf_pkg::IDX_TP_LATCH: rdata_d[1:0] = tp_latch_d;
                tbpaf_pkg::IDX_TP_DIR: rdata_d[1:0] = tp_dir_d;
                tbpaf_pkg::IDX_TP_FUNC: rdata_d[1:0] = tp_func_d;
                tbpaf_pkg::IDX_TP_READ: rdata_d[1:0] = tp_rb;
                tbpaf_pkg::IDX_UP_LATCH: rdata_d[1:0] = up_latch_d;
                tbpaf_pkg::IDX_UP_DIR: rdata_d[1:0] = up_dir_d;
                tbpaf_pkg::IDX_UP_FUNC: rdata_d[1:0] = up_func_d;
                tbpaf_pkg::IDX_UP_OTYPE: rdata_d[1:0] = up_otype_d;
                tbpaf_pkg::IDX_UP_PULLUP: rdata_d[1:0] = up_pullup_d;
                tbpaf_pkg::IDX_UP_READ: rdata_d[1:0] = up_rb;
                tbpaf_pkg::IDX_BP_LATCH: rdata_d[7:4] = bp_latch_d;
                tbpaf_pkg::IDX_BP_DIR: rdata_d[7:4] = bp_dir_d;
                tbpaf_pkg::IDX_BP_OTYPE: rdata_d[7:4] = bp_otype_d;
                tbpaf_pkg::IDX_BP_READ: rdata_d[7:4] = bp_rb;
                tbpaf_pkg::IDX_UART_ROUTE: rdata_d[tbpaf_pkg::SWAP_BIT] = swap_d;
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    // Read data captured at the address phase, held until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h00000000;
        end else if (acc_take && !hwrite) begin
            rdata_q <= rdata_d;
        end
    end

endmodule

// >>> tb/tbpaf_top_sva.sv
module tbpaf_top_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [1:0] tp_pin_in,
    input wire logic [1:0] tp_pin_oe_n,
    input wire logic [1:0] up_pin_in,
    input wire logic [1:0] up_pin_out,
    input wire logic [1:0] up_pin_oe_n,
    input wire logic [1:0] up_pullup_on,
    input wire logic timer_capture_in_a,
    input wire logic uart_b_receive
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Bus phases and port relations
    // ----------------------------------------------------------------
    logic hit2;
    // Any register of the two 2-bit ports
    assign hit2 = haddr[13:2] inside {tbpaf_pkg::IDX_TP_LATCH, tbpaf_pkg::IDX_UP_LATCH,
        tbpaf_pkg::IDX_TP_READ, tbpaf_pkg::IDX_UP_READ, tbpaf_pkg::IDX_TP_DIR,
        tbpaf_pkg::IDX_UP_DIR, tbpaf_pkg::IDX_UP_PULLUP, tbpaf_pkg::IDX_TP_FUNC,
        tbpaf_pkg::IDX_UP_FUNC, tbpaf_pkg::IDX_UP_OTYPE};
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_take(logic wr, logic [11:0] idx);
        hsel && hready && htrans[1] && hwrite == wr && haddr == {18'h0, idx, 2'b00};
    endsequence
    sequence s_rd2;
        hsel && hready && htrans[1] && !hwrite && hit2;
    endsequence
    a_dir_sets_drive : assert property (
        s_take(1'b1, tbpaf_pkg::IDX_TP_DIR) ##1 1'b1 |=> tp_pin_oe_n == ~$past(hwdata[1:0]))
        else $error("timer direction write did not reach the drivers");
    a_capture_follows : assert property (
        timer_capture_in_a == (tp_pin_oe_n[0] & tp_pin_in[0]))
        else $error("capture input does not follow the input pin");
    a_tp_readback : assert property (
        s_take(1'b0, tbpaf_pkg::IDX_TP_READ) |=> hrdata[1:0] == $past(tp_pin_in & tp_pin_oe_n))
        else $error("timer readback wrong");
    a_up_readback : assert property (
        s_take(1'b0, tbpaf_pkg::IDX_UP_READ) |=> hrdata[1:0] == $past(up_pin_in & up_pin_oe_n))
        else $error("uart readback wrong");
    a_pullup_not_push : assert property (
        (up_pullup_on & ~up_pin_oe_n & up_pin_out) == 2'b00)
        else $error("pull-up on while driving high");
    a_rx_from_pin : assert property (
        uart_b_receive == up_pin_in[0] || uart_b_receive == up_pin_in[1])
        else $error("receive input not taken from a port pin");
    a_upper_zero : assert property (
        s_rd2 |=> hrdata[31:2] == 30'h0)
        else $error("unused register bits read nonzero");
    a_reset_inputs : assert property (
        $rose(hresetn) |-> tp_pin_oe_n == 2'b11 && up_pin_oe_n == 2'b11 && up_pullup_on == 2'b00)
        else $error("pins not inputs after reset");
endmodule

bind tbpaf_top tbpaf_top_sva chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .tp_pin_in(tp_pin_in), .tp_pin_oe_n(tp_pin_oe_n), .up_pin_in(up_pin_in),
    .up_pin_out(up_pin_out), .up_pin_oe_n(up_pin_oe_n), .up_pullup_on(up_pullup_on),
    .timer_capture_in_a(timer_capture_in_a), .uart_b_receive(uart_b_receive)
);

// >>> tb/tbpaf_pin_model.sv
module tbpaf_pin_model (
    input wire logic hclk,
    input wire logic [7:0] drv_en,
    input wire logic [7:0] drv_val,
    input wire logic [7:0] oe_n,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pull,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic float_q = 1'b0;
    // Released unpulled lines wander, so a stale level never passes
    always @(posedge hclk) begin
        float_q <= ~float_q;
    end
    // Wire level: chip drive, else far side, else pull-up, else noise
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = !oe_n[i] ? pin_out[i] : drv_en[i] ? drv_val[i] : pull[i] ? 1'b1 : float_q;
        end
    end
endmodule

// >>> tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx_q = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, hresp, tp_pin_out, tp_pin_oe_n, up_pin_out, up_pin_oe_n;
    logic [1:0] up_pullup_on;
    logic [3:0] alt_q = 4'h0, bp_pin_out, bp_pin_oe_n;
    logic [7:0] drv_en = 8'hFF, drv_val = 8'h00, pins;
    logic hreadyout, timer_capture_in_a, timer_capture_in_b, uart_b_receive;
    logic [11:0] regs2 [8] = '{tbpaf_pkg::IDX_TP_LATCH, tbpaf_pkg::IDX_UP_LATCH,
        tbpaf_pkg::IDX_TP_DIR, tbpaf_pkg::IDX_UP_DIR, tbpaf_pkg::IDX_UP_PULLUP,
        tbpaf_pkg::IDX_TP_FUNC, tbpaf_pkg::IDX_UP_FUNC, tbpaf_pkg::IDX_UP_OTYPE};
    int n_fail = 0, check_count = 0;
    // ----------------------------------------------------------------
    // Clock, design and pin world
    // ----------------------------------------------------------------
    always #20 hclk = ~hclk;
    tbpaf_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tp_pin_in(pins[1:0]),
        .tp_pin_out(tp_pin_out), .tp_pin_oe_n(tp_pin_oe_n), .up_pin_in(pins[3:2]),
        .up_pin_out(up_pin_out), .up_pin_oe_n(up_pin_oe_n), .up_pullup_on(up_pullup_on),
        .bp_pin_in(pins[7:4]), .bp_pin_out(bp_pin_out), .bp_pin_oe_n(bp_pin_oe_n),
        .pulse_out_a(alt_q[0]), .pulse_out_b(alt_q[1]), .pwm_out_a(alt_q[2]),
        .pwm_out_b(alt_q[3]), .timer_capture_in_a(timer_capture_in_a),
        .timer_capture_in_b(timer_capture_in_b), .uart_b_transmit(tx_q),
        .uart_b_receive(uart_b_receive));
    tbpaf_pin_model pin_u (.hclk(hclk), .drv_en(drv_en), .drv_val(drv_val),
        .oe_n({bp_pin_oe_n, up_pin_oe_n, tp_pin_oe_n}), .pin_out({bp_pin_out, up_pin_out,
        tp_pin_out}), .pull({4'h0, up_pullup_on, 2'h0}), .pin_in(pins));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bounded wait for hready high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            end_sim();
        end
    endtask
    // One single-word transfer; entered right after a rising edge
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
            output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {18'h0, idx, 2'b00};
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
        logic [31:0] unused;
        bus(1'b1, idx, wd, unused);
    endtask
    task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, idx, 32'h0, got);
        chk(got, exp);
    endtask
    // Main sequence; pin checks sit 1 ns after the edge that updated them
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs2[i]) rdchk(regs2[i], 32'h0);
        wr(12'h100, 32'hFF);
        rdchk(12'h100, 32'h0);
        chk(32'(hresp), 32'(tbpaf_pkg::HRESP_OKAY));
        foreach (regs2[i]) begin
            wr(regs2[i], 32'hFFFF_FFFF);
            rdchk(regs2[i], 32'h3);
            wr(regs2[i], 32'h0);
        end
        drv_val <= 8'h02;
        rdchk(tbpaf_pkg::IDX_TP_READ, 32'h2);
        wr(tbpaf_pkg::IDX_TP_LATCH, 32'h1);
        wr(tbpaf_pkg::IDX_TP_DIR, 32'h3);
        #1;
        chk(32'(tp_pin_oe_n), 32'h0);
        chk(32'(tp_pin_out), 32'h1);
        chk(32'(timer_capture_in_a), 32'h0);
        @(posedge hclk);
        rdchk(tbpaf_pkg::IDX_TP_READ, 32'h0);
        wr(tbpaf_pkg::IDX_TP_DIR, 32'h1);
        #1;
        chk(32'(tp_pin_oe_n), 32'h2);
        chk(32'(timer_capture_in_b), 32'h1);
        @(posedge hclk);
        wr(tbpaf_pkg::IDX_TP_DIR, 32'h3);
        wr(tbpaf_pkg::IDX_TP_FUNC, 32'h3);
        for (int k = 0; k < 4; k++) begin
            alt_q <= 4'(1 << k);
            #1;
            chk(32'(tp_pin_out), (k % 2 == 0) ? 32'h1 : 32'h2);
            @(posedge hclk);
        end
        drv_en <= 8'hF3;
        wr(tbpaf_pkg::IDX_UP_DIR, 32'h3);
        wr(tbpaf_pkg::IDX_UP_OTYPE, 32'h1);
        wr(tbpaf_pkg::IDX_UP_LATCH, 32'h3);
        wr(tbpaf_pkg::IDX_UP_PULLUP, 32'h3);
        #1;
        chk(32'(up_pin_oe_n), 32'h1);
        chk(32'(up_pin_out[1]), 32'h1);
        chk(32'(up_pullup_on), 32'h1);
        @(posedge hclk);
        rdchk(tbpaf_pkg::IDX_UP_READ, 32'h1);
        wr(tbpaf_pkg::IDX_UP_LATCH, 32'h0);
        #1;
        chk(32'({up_pin_oe_n, up_pin_out}), 32'h0);
        @(posedge hclk);
        wr(tbpaf_pkg::IDX_UP_DIR, 32'h0);
        #1;
        chk(32'(up_pullup_on), 32'h3);
        @(posedge hclk);
        rdchk(tbpaf_pkg::IDX_UP_READ, 32'h3);
        wr(tbpaf_pkg::IDX_UP_DIR, 32'h3);
        wr(tbpaf_pkg::IDX_UP_OTYPE, 32'h0);
        wr(tbpaf_pkg::IDX_UP_FUNC, 32'h3);
        for (int v = 0; v < 2; v++) begin
            tx_q <= 1'(v);
            #1;
            chk(32'(up_pin_out), (v == 1) ? 32'h1 : 32'h0);
            @(posedge hclk);
        end
        wr(tbpaf_pkg::IDX_UP_DIR, 32'h0);
        drv_en <= 8'hFF;
        drv_val <= 8'h08;
        #1;
        chk(32'(uart_b_receive), 32'h1);
        @(posedge hclk);
        wr(tbpaf_pkg::IDX_UART_ROUTE, 32'h2);
        #1;
        chk(32'(uart_b_receive), 32'h0);
        @(posedge hclk);
        wr(tbpaf_pkg::IDX_UP_DIR, 32'h3);
        #1;
        chk(32'(up_pin_out), 32'h2);
        @(posedge hclk);
        wr(tbpaf_pkg::IDX_BP_DIR, 32'hF0);
        wr(tbpaf_pkg::IDX_BP_LATCH, 32'hA0);
        #1;
        chk(32'({bp_pin_oe_n, bp_pin_out}), 32'h0A);
        @(posedge hclk);
        rdchk(tbpaf_pkg::IDX_BP_LATCH, 32'hA0);
        drv_val <= 8'h28;
        wr(tbpaf_pkg::IDX_BP_OTYPE, 32'h30);
        #1;
        chk(32'({bp_pin_oe_n, bp_pin_out}), 32'h28);
        @(posedge hclk);
        rdchk(tbpaf_pkg::IDX_BP_READ, 32'h20);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        chk(32'({tp_pin_oe_n, up_pin_oe_n, bp_pin_oe_n, up_pullup_on}), 32'h3FC);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(tbpaf_pkg::IDX_UP_PULLUP, 32'h0);
        rdchk(tbpaf_pkg::IDX_TP_DIR, 32'h0);
        end_sim();
    end
endmodule
